// ===== bench/tag_config_write_commands_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcw_regs.vh"
module tag_config_write_commands_bench;
  logic aclk = 1'b0, aresetn = 1'b0, cmd_valid = 1'b0, carrier_present = 1'b0;
  logic [63:0] cmd_frame = 64'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0, lat = 4'h1;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] fails = 2'h0;
  wire logic cmd_ready, rsp_valid, head_wr_req, head_verify, head_wr_done, head_wr_ok;
  wire logic win_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, irq;
  wire logic [63:0] rsp_frame;
  wire logic [7:0] head_wr_addr, win_last_word, win_first_word, fix_prog_len, fix_read_len;
  wire logic [31:0] head_wr_data, s_axi_rdata;
  wire logic [15:0] ctrl_hi_bits;
  wire logic [1:0] fix_prog_src, fix_read_src, s_axi_bresp, s_axi_rresp;
  int mismatches = 0, samples_checked = 0;
  logic [7:0] rcnt = 8'h0, b1;
  logic [63:0] exp_q[$]; // Replies still owed by the design, oldest first.
  logic [15:0] tt [4] = '{`TCW_TT_02, `TCW_TT_11, `TCW_TT_50, `TCW_TT_52};
  logic [1:0] rsrc [4] = '{`TCW_SRC_FAM1_CODE, `TCW_SRC_FAM1_CODE,
                           `TCW_SRC_FAM2_NATIVE, `TCW_SRC_FAM2_COMPAT};
  tcw_cmd_unit dut_u (.aclk, .aresetn, .cmd_valid, .cmd_ready, .cmd_frame, .rsp_valid,
    .rsp_frame, .carrier_present, .head_wr_req, .head_wr_addr, .head_wr_data,
    .head_verify, .head_wr_done, .head_wr_ok, .ctrl_hi_bits, .win_last_word,
    .win_first_word, .win_valid, .fix_prog_src, .fix_read_src, .fix_prog_len,
    .fix_read_len, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  tcw_head_model head_u (.aclk, .aresetn, .lat, .fails, .head_wr_req, .head_wr_done,
    .head_wr_ok);
  always #12.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Both channels offered together; each dropped at the edge that takes it.
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_awready || !s_axi_awvalid) || !(s_axi_wready || !s_axi_wvalid));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(64'(s_axi_bresp), 64'h0);
    // One idle edge so a following call never re-raises bready in this step.
    @(posedge aclk);
  endtask
  // Reads one word and compares {resp, data & m} with e.
  task automatic axr(input logic [3:0] a, input logic [31:0] m, input logic [33:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check({30'h0, s_axi_rresp, s_axi_rdata & m}, {30'h0, e});
    @(posedge aclk);
  endtask
  task automatic expect_rsp(input logic [7:0] st);
    rcnt = rcnt + 8'h01;
    exp_q.push_back({`TCW_CMD_BUF_CFG_WR, 4'h0, b1[3:0], st, rcnt, 32'h0});
  endtask
  task automatic send;
    cmd_frame <= {`TCW_CMD_BUF_CFG_WR, b1, 8'h00, `TCW_CFG_CTRL_WORD, d};
    cmd_valid <= 1'b1;
    do @(posedge aclk); while (!cmd_ready);
    cmd_valid <= 1'b0;
  endtask
  task automatic drain;
    while (exp_q.size() != 0) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rcnt = 8'h0;
  endtask
  // Every reply is matched against the oldest note.
  always @(posedge aclk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(64'(rsp_valid), 64'h0);
      else check(rsp_frame, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    wrap_up;
  end
  initial begin
    void'($urandom(10254));
    do_reset;
    axr(`TCW_REG_CTRL, 32'hFFFF_FFFF, {2'b00, `TCW_CTRL_RST});
    axr(`TCW_REG_IRQ_MASK, 32'hFFFF_FFFF, 34'h0);
    axr(4'h6, 32'hFFFF_FFFF, {2'b10, 32'h0});
    for (int i = 0; i < 4; i++) begin
      axw(`TCW_REG_CTRL, {tt[i], 16'h0});
      check(64'(fix_read_src), 64'(rsrc[i]));
      if (i == 2) check({fix_prog_src, fix_prog_len, fix_read_len},
        {`TCW_SRC_FAM2_COMPAT, `TCW_COMPAT_BYTES, `TCW_NATIVE_BYTES});
    end
    // Channel 1 with a random toggle; password still off.
    b1 = {7'h01, 1'($urandom)};
    d = {16'($urandom), `TCW_FIRST_DATA_WORD, `TCW_FIRST_DATA_WORD};
    carrier_present <= 1'b1;
    expect_rsp(`TCW_ST_PWD_OFF);
    send;
    drain;
    do_reset;
    axw(`TCW_REG_CTRL, 32'h1);
    carrier_present <= 1'b0;
    expect_rsp(`TCW_ST_NO_CARRIER);
    send;
    drain;
    do_reset;
    // Full job: two bad attempts, a brief gap, then a real loss.
    axw(`TCW_REG_CTRL, 32'h1);
    fails <= 2'h2;
    lat <= 4'($urandom_range(4, 1));
    carrier_present <= 1'b1;
    expect_rsp(`TCW_ST_OK);
    send;
    drain;
    check(64'({ctrl_hi_bits, win_last_word, win_first_word, win_valid}), 64'({d, 1'b1}));
    expect_rsp(`TCW_ST_OK);
    carrier_present <= 1'b0;
    @(posedge aclk);
    carrier_present <= 1'b1;
    drain;
    expect_rsp(`TCW_ST_NO_CARRIER);
    carrier_present <= 1'b0;
    drain;
    axr(`TCW_REG_STATUS, 32'hFFFF_FF00, {2'b00, rcnt, `TCW_ST_NO_CARRIER, 8'h04, 8'h00});
    check(64'(irq), 64'h0);
    axw(`TCW_REG_IRQ_MASK, 32'h7);
    check(64'(irq), 64'h1);
    axr(`TCW_REG_IRQ_STAT, 32'h3, {2'b00, 32'h3});
    check(64'(irq), 64'h0);
    wrap_up;
  end
endmodule
`default_nettype wire

// ===== bench/tcw_cmd_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcw_regs.vh"
// Port-level checker for the command unit.
module tcw_cmd_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [63:0] cmd_frame,
  input wire logic        rsp_valid,
  input wire logic [63:0] rsp_frame,
  input wire logic        carrier_present,
  input wire logic        head_wr_req,
  input wire logic [7:0]  head_wr_addr,
  input wire logic [31:0] head_wr_data,
  input wire logic        head_verify,
  input wire logic        head_wr_done,
  input wire logic        head_wr_ok,
  input wire logic [15:0] ctrl_hi_bits,
  input wire logic [7:0]  win_last_word,
  input wire logic [7:0]  win_first_word,
  input wire logic        win_valid,
  input wire logic [1:0]  fix_prog_src,
  input wire logic [1:0]  fix_read_src,
  input wire logic [7:0]  fix_prog_len,
  input wire logic [7:0]  fix_read_len
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [63:0] frame_ff; // Last frame taken, the cause of every job and reply.
  logic        ok_w;     // A head attempt that ended well.
  assign ok_w = head_wr_req && head_wr_done && head_wr_ok;
  // Keep the accepted frame so later outputs can be traced back to it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      frame_ff <= 64'h0;
    end else if (cmd_valid && cmd_ready) begin
      frame_ff <= cmd_frame;
    end
  end
  property p_no_verify; head_verify == 1'b0; endproperty
  a_no_verify: assert property (p_no_verify) else $error("verify mode raised");
  property p_job;
    head_wr_req |-> head_wr_addr == frame_ff[39:32] && head_wr_data == frame_ff[31:0];
  endproperty
  a_job: assert property (p_job) else $error("head job differs from frame");
  property p_retry; head_wr_req && head_wr_done && !head_wr_ok |=> head_wr_req; endproperty
  a_retry: assert property (p_retry) else $error("write not retried");
  property p_ok_rsp; ok_w |=> rsp_valid && rsp_frame[47:40] == `TCW_ST_OK; endproperty
  a_ok_rsp: assert property (p_ok_rsp) else $error("no good reply after write");
  property p_echo;
    rsp_valid |-> rsp_frame[63:56] == frame_ff[63:56]
      && rsp_frame[55:48] == {4'h0, frame_ff[51:48]} && rsp_frame[31:0] == 32'h0;
  endproperty
  a_echo: assert property (p_echo) else $error("reply header wrong");
  property p_absent;
    rsp_valid && rsp_frame[47:40] == `TCW_ST_NO_CARRIER |-> !$past(carrier_present);
  endproperty
  a_absent: assert property (p_absent) else $error("05h with carrier present");
  property p_brief_gap;
    $fell(carrier_present) ##1 carrier_present
      |-> (!rsp_valid || rsp_frame[47:40] != `TCW_ST_NO_CARRIER) [*4];
  endproperty
  a_brief_gap: assert property (p_brief_gap) else $error("05h between carriers");
  property p_window;
    ok_w && head_wr_addr == `TCW_CFG_CTRL_WORD |-> ##[1:2] (win_valid
      && ctrl_hi_bits == frame_ff[31:16] && win_last_word == frame_ff[15:8]
      && win_first_word == frame_ff[7:0]);
  endproperty
  a_window: assert property (p_window) else $error("window not updated");
  property p_native;
    fix_read_src == `TCW_SRC_FAM2_NATIVE |-> fix_read_len == `TCW_NATIVE_BYTES;
  endproperty
  a_native: assert property (p_native) else $error("native length wrong");
  property p_compat;
    fix_prog_src == `TCW_SRC_FAM2_COMPAT |-> fix_prog_len == `TCW_COMPAT_BYTES;
  endproperty
  a_compat: assert property (p_compat) else $error("compat length wrong");
  c_ok: cover property (ok_w);
  c_retry: cover property (head_wr_done && !head_wr_ok);
  c_lost: cover property (rsp_valid && rsp_frame[47:40] == `TCW_ST_NO_CARRIER);
endmodule
bind tcw_cmd_unit tcw_cmd_props u_props (.aclk, .aresetn, .cmd_valid, .cmd_ready,
  .cmd_frame, .rsp_valid, .rsp_frame, .carrier_present, .head_wr_req, .head_wr_addr,
  .head_wr_data, .head_verify, .head_wr_done, .head_wr_ok, .ctrl_hi_bits,
  .win_last_word, .win_first_word, .win_valid, .fix_prog_src, .fix_read_src,
  .fix_prog_len, .fix_read_len);
`default_nettype wire

// ===== bench/tcw_head_model.sv
`timescale 1ns/1ps
`default_nettype none
// Read/write head: each attempt answers lat+1 cycles after it starts, the first fails come back bad.
module tcw_head_model (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [3:0] lat,
  input wire logic [1:0] fails,
  input wire logic       head_wr_req,
  output var logic       head_wr_done,
  output var logic       head_wr_ok
);
  logic [3:0] wait_ff;  // Cycles spent on this attempt.
  logic [1:0] tries_ff; // Bad attempts so far in this job.
  // Outside a done pulse ok toggles, so an unqualified read of it is caught.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wait_ff <= 4'h0;
      tries_ff <= 2'h0;
      head_wr_done <= 1'b0;
      head_wr_ok <= 1'b0;
    end else begin
      head_wr_done <= 1'b0;
      head_wr_ok <= ~head_wr_ok;
      if (!head_wr_req || head_wr_done) begin
        wait_ff <= 4'h0;
        if (!head_wr_req) tries_ff <= 2'h0;
      end else if (wait_ff >= lat) begin
        head_wr_done <= 1'b1;
        head_wr_ok <= (tries_ff >= fails);
        if (tries_ff < fails) tries_ff <= tries_ff + 2'h1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tcw_axil_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "tcw_regs.vh"
// AXI4-Lite slave holding control, mask and read-to-clear event status.
module tcw_axil_slave (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  input  wire [3:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  input  wire [31:0] status_in,
  input  wire [2:0]  events,
  output wire [31:0] ctrl,
  output wire        irq
);
  reg [31:0] ctrl_ff;   // Software control word.
  reg [2:0]  ist_ff;    // Sticky event bits.
  reg [2:0]  imask_ff;  // Interrupt enables.
  reg [3:0]  awa_ff;    // Held write address.
  reg        awh_ff;    // Write address held.
  reg [31:0] wd_ff;     // Held write data.
  reg [3:0]  ws_ff;     // Held strobes.
  reg        wh_ff;     // Write data held.
  reg        bv_ff;     // Write response pending.
  reg        rv_ff;     // Read response pending.
  reg [31:0] rd_ff;     // Read data.
  reg [1:0]  rr_ff;     // Read response code.
  reg [1:0]  br_ff;     // Write response code.
  wire       wr_go;
  wire       rd_go;
  wire       clr_ist;
  integer    i;
  assign awready = !awh_ff && !bv_ff;
  assign wready  = !wh_ff && !bv_ff;
  assign arready = !rv_ff;
  assign bvalid  = bv_ff;
  assign bresp   = br_ff;
  assign rvalid  = rv_ff;
  assign rdata   = rd_ff;
  assign rresp   = rr_ff;
  assign ctrl    = ctrl_ff;
  assign irq     = |(ist_ff & imask_ff);
  // Address and data may arrive in either order; commit once both are held.
  assign wr_go   = awh_ff && wh_ent(wh_ff) && !bv_ff;
  assign rd_go   = arvalid && !rv_ff;
  assign clr_ist = rd_go && (araddr == `TCW_REG_IRQ_STAT);
  function wh_ent;
    input v;
    wh_ent = v;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture and register update.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awh_ff <= 1'b0;
      wh_ff <= 1'b0;
      awa_ff <= 4'h0;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
      ctrl_ff <= `TCW_CTRL_RST;
      imask_ff <= 3'h0;
    end else begin
      if (awvalid && awready) begin
        awh_ff <= 1'b1;
        awa_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wh_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (wr_go) begin
        awh_ff <= 1'b0;
        wh_ff <= 1'b0;
        bv_ff <= 1'b1;
        br_ff <= 2'h0;
        // Status registers ignore writes; unmapped offsets answer SLVERR.
        if (awa_ff == `TCW_REG_CTRL) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (ws_ff[i]) begin
              ctrl_ff[i*8 +: 8] <= wd_ff[i*8 +: 8];
            end
          end
        end else if (awa_ff == `TCW_REG_IRQ_MASK) begin
          if (ws_ff[0]) begin
            imask_ff <= wd_ff[2:0];
          end
        end else if (awa_ff != `TCW_REG_STATUS && awa_ff != `TCW_REG_IRQ_STAT) begin
          br_ff <= 2'h2;
        end
      end else if (bv_ff && bready) begin
        bv_ff <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read channel; a read of the event register clears it, new events win.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= 2'h0;
      ist_ff <= 3'h0;
    end else begin
      ist_ff <= (clr_ist ? 3'h0 : ist_ff) | events;
      if (rd_go) begin
        rv_ff <= 1'b1;
        rr_ff <= 2'h0;
        case (araddr)
          `TCW_REG_CTRL:      rd_ff <= ctrl_ff;
          `TCW_REG_STATUS:    rd_ff <= status_in;
          `TCW_REG_IRQ_STAT:  rd_ff <= {29'h0000_0000, ist_ff};
          `TCW_REG_IRQ_MASK:  rd_ff <= {29'h0000_0000, imask_ff};
          default: begin
            rd_ff <= 32'h0000_0000;
            rr_ff <= 2'h2;
          end
        endcase
      end else if (rv_ff && rready) begin
        rv_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tcw_cmd_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "tcw_regs.vh"
module tcw_cmd_unit (
  input  wire        aclk,
  input  wire        aresetn,
  // Command frame from the fieldbus side, eight bytes.
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [63:0] cmd_frame,
  // Response frame back to the fieldbus side.
  output wire        rsp_valid,
  output wire [63:0] rsp_frame,
  // Head side: carrier presence and configuration write job.
  input  wire        carrier_present,
  output wire        head_wr_req,
  output wire [7:0]  head_wr_addr,
  output wire [31:0] head_wr_data,
  output wire        head_verify,
  input  wire        head_wr_done,
  input  wire        head_wr_ok,
  // Control word window seen by read commands, then fixcode targets and lengths for the tag type.
  output wire [15:0] ctrl_hi_bits,
  output wire [7:0]  win_last_word,
  output wire [7:0]  win_first_word,
  output wire        win_valid,
  output wire [1:0]  fix_prog_src,
  output wire [1:0]  fix_read_src,
  output wire [7:0]  fix_prog_len,
  output wire [7:0]  fix_read_len,
  // AXI4-Lite register port.
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        irq
);
  ////////////////////////////////////////////////////////////////////////////
  // States of the buffered configuration write.
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_WRITE = 3'h2;
  localparam [2:0] ST_WAIT  = 3'h3;
  localparam [2:0] ST_GONE  = 3'h4;
  localparam [2:0] ST_ARRIV = 3'h5;

  reg [2:0]  state_ff;      // Command sequencer state.
  reg [2:0]  nxt_state;
  reg [7:0]  cmd_code_ff;   // Active command code.
  reg [7:0]  chan_ff;       // Channel and toggle byte.
  reg [7:0]  cfg_addr_ff;   // Configuration word address.
  reg [31:0] cfg_data_ff;   // Configuration word data.
  reg        req_ff;        // Head write request level.
  reg        rsp_v_ff;      // Response valid pulse.
  reg [7:0]  rsp_st_ff;     // Last status byte.
  reg [7:0]  rsp_cnt_ff;    // Reply counter.
  reg [31:0] ctrlw_ff;      // Last written control word.
  reg        win_v_ff;      // Control word has been written.
  reg [2:0]  evt_ff;        // One-cycle event pulses.
  reg        prev_car_ff;   // Carrier presence one cycle ago.
  reg        nxt_rsp;
  reg [7:0]  nxt_st;
  wire [31:0] sw_ctrl;      // Software control register.
  wire        pwd_mode;
  wire [15:0] tag_type;
  wire        accept;
  wire        is_buf_cfg;

  assign pwd_mode   = sw_ctrl[`TCW_CTRL_PWD_BIT];
  assign tag_type   = sw_ctrl[`TCW_CTRL_TT_LSB +: 16];
  assign cmd_ready  = (state_ff == ST_IDLE);
  assign accept     = cmd_valid && cmd_ready;
  assign is_buf_cfg = (cmd_frame[63:56] == `TCW_CMD_BUF_CFG_WR);
  assign head_wr_req  = req_ff;
  assign head_wr_addr = cfg_addr_ff;
  assign head_wr_data = cfg_data_ff;
  assign head_verify  = 1'b0;
  assign rsp_valid  = rsp_v_ff;
  // Byte 0 echo code, byte 1 channel and toggle, then status and counter.
  assign rsp_frame  = {cmd_code_ff, chan_ff, rsp_st_ff, rsp_cnt_ff, 32'h0000_0000};
  assign ctrl_hi_bits   = ctrlw_ff[31:16];
  assign win_last_word  = ctrlw_ff[15:8];
  assign win_first_word = ctrlw_ff[7:0];
  assign win_valid      = win_v_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: a write is issued only with a carrier present, retried on
  // failure, and the command rearms on each new carrier.
  always @* begin
    nxt_state = state_ff;
    nxt_rsp   = 1'b0;
    nxt_st    = rsp_st_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept && is_buf_cfg) begin
          nxt_state = ST_START;
        end else if (accept) begin
          // Other commands are handled elsewhere; answer with the echo only.
          nxt_rsp = 1'b1;
          nxt_st  = `TCW_ST_OK;
        end
      end
      ST_START: begin
        if (!pwd_mode) begin
          // Without password mode the configuration range stays locked.
          nxt_state = ST_IDLE;
          nxt_rsp   = 1'b1;
          nxt_st    = `TCW_ST_PWD_OFF;
        end else if (!carrier_present) begin
          nxt_state = ST_GONE;
          nxt_rsp   = 1'b1;
          nxt_st    = `TCW_ST_NO_CARRIER;
        end else begin
          nxt_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (head_wr_done && head_wr_ok) begin
          nxt_state = ST_WAIT;
          nxt_rsp   = 1'b1;
          nxt_st    = `TCW_ST_OK;
        end else if (!carrier_present) begin
          nxt_state = ST_GONE;
          nxt_rsp   = 1'b1;
          nxt_st    = `TCW_ST_NO_CARRIER;
        end
        // A failed attempt keeps the request up, so the head tries again.
      end
      ST_WAIT: begin
        // A new carrier may follow after one cycle of absence; restart silently.
        if (!carrier_present) begin
          nxt_state = ST_ARRIV;
        end
      end
      ST_ARRIV: begin
        // One cycle of absence: if a carrier is back already the swap was
        // immediate and no 05h is given.
        if (carrier_present) begin
          nxt_state = ST_START;
        end else begin
          nxt_state = ST_GONE;
          nxt_rsp   = 1'b1;
          nxt_st    = `TCW_ST_NO_CARRIER;
        end
      end
      ST_GONE: begin
        if (carrier_present) begin
          nxt_state = ST_START;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered command fields, head request and response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= ST_IDLE;
      cmd_code_ff <= 8'h00;
      chan_ff     <= 8'h00;
      cfg_addr_ff <= 8'h00;
      cfg_data_ff <= 32'h0000_0000;
      req_ff      <= 1'b0;
      rsp_v_ff    <= 1'b0;
      rsp_st_ff   <= 8'h00;
      rsp_cnt_ff  <= 8'h00;
      prev_car_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      rsp_v_ff    <= nxt_rsp;
      rsp_st_ff   <= nxt_st;
      prev_car_ff <= carrier_present;
      if (nxt_rsp) begin
        rsp_cnt_ff <= rsp_cnt_ff + 8'h01;
      end
      if (accept) begin
        cmd_code_ff <= cmd_frame[63:56];
        chan_ff     <= {4'h0, cmd_frame[51:48]};
        cfg_addr_ff <= cmd_frame[39:32];
        cfg_data_ff <= cmd_frame[31:0];
      end
      // Request holds through failed attempts until one succeeds or the carrier is lost.
      req_ff <= (nxt_state == ST_WRITE) && !(head_wr_done && head_wr_ok);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control word capture and event pulses for the interrupt logic.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrlw_ff <= 32'h0000_0000;
      win_v_ff <= 1'b0;
      evt_ff   <= 3'h0;
    end else begin
      evt_ff <= {carrier_present && !prev_car_ff,
                 nxt_rsp && (nxt_st == `TCW_ST_NO_CARRIER),
                 state_ff == ST_WRITE && head_wr_done && head_wr_ok};
      if (state_ff == ST_WRITE && head_wr_done && head_wr_ok &&
          cfg_addr_ff == `TCW_CFG_CTRL_WORD) begin
        ctrlw_ff <= cfg_data_ff;
        win_v_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register slave and tag type decode.
  tcw_axil_slave u_regs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (s_axi_awaddr),
    .awvalid   (s_axi_awvalid),
    .awready   (s_axi_awready),
    .wdata     (s_axi_wdata),
    .wstrb     (s_axi_wstrb),
    .wvalid    (s_axi_wvalid),
    .wready    (s_axi_wready),
    .bresp     (s_axi_bresp),
    .bvalid    (s_axi_bvalid),
    .bready    (s_axi_bready),
    .araddr    (s_axi_araddr),
    .arvalid   (s_axi_arvalid),
    .arready   (s_axi_arready),
    .rdata     (s_axi_rdata),
    .rresp     (s_axi_rresp),
    .rvalid    (s_axi_rvalid),
    .rready    (s_axi_rready),
    .status_in ({rsp_cnt_ff, rsp_st_ff, 5'h00, win_v_ff, carrier_present, 1'b0, 5'h00, state_ff}),
    .events    (evt_ff),
    .ctrl      (sw_ctrl),
    .irq       (irq)
  );

  tcw_fix_select u_fix (
    .tag_type (tag_type),
    .prog_src (fix_prog_src),
    .read_src (fix_read_src),
    .prog_len (fix_prog_len),
    .read_len (fix_read_len)
  );
endmodule
`default_nettype wire

// ===== rtl/tcw_fix_select.v
`timescale 1ns/1ps
`default_nettype none
`include "tcw_regs.vh"
// Decides what the fixcode program and read commands act on for a tag type.
module tcw_fix_select (
  input  wire [15:0] tag_type,
  output reg  [1:0]  prog_src,
  output reg  [1:0]  read_src,
  output reg  [7:0]  prog_len,
  output reg  [7:0]  read_len
);
  // Program and read targets differ for types 50 and 52, hence two decodes.
  always @* begin
    prog_src = `TCW_SRC_NONE;
    read_src = `TCW_SRC_NONE;
    prog_len = 8'h00;
    read_len = 8'h00;
    case (tag_type)
      `TCW_TT_02, `TCW_TT_11: begin
        prog_src = `TCW_SRC_FAM1_CODE;
        read_src = `TCW_SRC_FAM1_CODE;
      end
      `TCW_TT_50: begin
        prog_src = `TCW_SRC_FAM2_COMPAT;
        prog_len = `TCW_COMPAT_BYTES;
        read_src = `TCW_SRC_FAM2_NATIVE;
        read_len = `TCW_NATIVE_BYTES;
      end
      `TCW_TT_52: begin
        read_src = `TCW_SRC_FAM2_COMPAT;
        read_len = `TCW_COMPAT_BYTES;
      end
      default: begin
        prog_src = `TCW_SRC_NONE;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/tcw_regs.vh
`ifndef TCW_REGS_VH
`define TCW_REGS_VH
// Command and status codes.
`define TCW_CMD_BUF_CFG_WR    8'h66
`define TCW_CMD_SGL_CFG_WR    8'h12
`define TCW_CMD_SGL_FIX_PROG  8'h1F
`define TCW_CMD_BUF_FIX_PROG  8'h24
`define TCW_CMD_SGL_FIX_READ  8'h46
`define TCW_CMD_BUF_FIX_READ  8'h47
`define TCW_ST_OK             8'h00
`define TCW_ST_NO_CARRIER     8'h05
`define TCW_ST_PWD_OFF        8'h0A
// Configuration word addresses.
`define TCW_CFG_CTRL_WORD     8'h02
`define TCW_FIRST_DATA_WORD   8'h03
// Tag type codes, two ASCII characters.
`define TCW_TT_02             16'h3032
`define TCW_TT_11             16'h3131
`define TCW_TT_50             16'h3530
`define TCW_TT_52             16'h3532
// Read source selection reported for fixcode reads.
`define TCW_SRC_NONE          2'h0
`define TCW_SRC_FAM1_CODE     2'h1
`define TCW_SRC_FAM2_COMPAT   2'h2
`define TCW_SRC_FAM2_NATIVE   2'h3
`define TCW_COMPAT_BYTES      8'h08
`define TCW_NATIVE_BYTES      8'h04
// AXI4-Lite register byte offsets.
`define TCW_REG_CTRL          4'h0
`define TCW_REG_STATUS        4'h4
`define TCW_REG_IRQ_STAT      4'h8
`define TCW_REG_IRQ_MASK      4'hC
// Control register fields.
`define TCW_CTRL_PWD_BIT      0
`define TCW_CTRL_TT_LSB       16
`define TCW_CTRL_RST          32'h0000_0000
`define TCW_IRQ_W             3
`endif
